// ---- common/otsc_defs.vh ----
`ifndef OTSC_DEFS_VH
`define OTSC_DEFS_VH

// ----------------------------------------------------------------
// clock and debounce timing
// ----------------------------------------------------------------
`define OTSC_CLK_MHZ        200
`define OTSC_DEBOUNCE_US    100
`define OTSC_DB_CYCLES      16'h4e20 // 100 us at 200 MHz, sized for the counter
`define OTSC_DB_CW          16

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define OTSC_N_AXIS         2
`define OTSC_N_TERM         8
`define OTSC_N_OUT          6
`define OTSC_SEL_W          4
`define OTSC_TQ_W           9
`define OTSC_ST_W           4

// ----------------------------------------------------------------
// input terminal selection codes
// ----------------------------------------------------------------
`define OTSC_SEL_FIRST      4'h1
`define OTSC_SEL_LAST       4'h8
`define OTSC_SEL_OFF        4'h9
`define OTSC_POS_SEL_A_DEF  4'h3
`define OTSC_POS_SEL_B_DEF  4'h7
`define OTSC_NEG_SEL_A_DEF  4'h4
`define OTSC_NEG_SEL_B_DEF  4'h8

// ----------------------------------------------------------------
// stop method digits
// ----------------------------------------------------------------
`define OTSC_MID_PLUG       4'h0
`define OTSC_MID_COAST      4'h1
`define OTSC_TOP_PLUG       4'h0
`define OTSC_TOP_CLAMP      4'h1
`define OTSC_TOP_COAST      4'h2

// ----------------------------------------------------------------
// stop torque in percent of rated
// ----------------------------------------------------------------
`define OTSC_TQ_LIMIT       9'h12c
`define OTSC_TQ_DEF         9'h12c

// ----------------------------------------------------------------
// brake output terminal selection
// ----------------------------------------------------------------
`define OTSC_BK_NONE        4'h0
`define OTSC_BK_FIRST       4'h1

`endif

// ---- core/otsc_debounce.v ----
`timescale 1ns/10ps
`default_nettype none
`include "otsc_defs.vh"

module otsc_debounce
#(
   parameter [`OTSC_DB_CW-1:0] CYCLES = `OTSC_DB_CYCLES
)
(
   input  wire clk_in,
   input  wire rstn_in,
   input  wire ce_in,
   input  wire pin_in,
   output reg  level_out
);

   reg                   sync1;
   reg                   sync2;
   reg [`OTSC_DB_CW-1:0] count;

   // ----------------------------------------------------------------
   // two-flop synchroniser, then a stability counter
   // ----------------------------------------------------------------
   // level only moves after the pin has held still for CYCLES clocks,
   // so contact bounce never reaches the stop logic
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sync1     <= 1'b0;
         sync2     <= 1'b0;
         count     <= {`OTSC_DB_CW{1'b0}};
         level_out <= 1'b0;
      end
      else if (ce_in)
      begin
         sync1 <= pin_in;
         sync2 <= sync1;
         if (sync2 == level_out)
            count <= {`OTSC_DB_CW{1'b0}};
         else if (count >= CYCLES - 1'b1)
         begin
            count     <= {`OTSC_DB_CW{1'b0}};
            level_out <= sync2;
         end
         else
            count <= count + 1'b1;
      end
   end

endmodule
`default_nettype wire

// ---- core/otsc_top.v ----
`timescale 1ns/10ps
`default_nettype none
`include "otsc_defs.vh"

module otsc_top
#(
   parameter [`OTSC_DB_CW-1:0] DEBOUNCE_CYCLES = `OTSC_DB_CYCLES
)
(
   input  wire                                clk_in,
   input  wire                                rstn_in,
   input  wire                                ce_in,
   input  wire [`OTSC_N_TERM-1:0]             term_in,
   input  wire [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] cfg_pos_sel_in,
   input  wire [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] cfg_neg_sel_in,
   input  wire [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] cfg_stop_mid_in,
   input  wire [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] cfg_stop_top_in,
   input  wire [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] cfg_brake_sel_in,
   input  wire [`OTSC_N_AXIS*`OTSC_TQ_W-1:0]  stop_torque_in,
   input  wire [`OTSC_N_AXIS*`OTSC_TQ_W-1:0]  max_torque_in,
   input  wire [`OTSC_N_AXIS-1:0]             servo_on_in,
   input  wire [`OTSC_N_AXIS-1:0]             moving_in,
   input  wire [`OTSC_N_AXIS-1:0]             dir_pos_in,
   input  wire [`OTSC_N_AXIS-1:0]             stopped_in,
   input  wire [`OTSC_N_AXIS-1:0]             cmd_move_in,
   input  wire [`OTSC_N_AXIS-1:0]             cmd_dir_pos_in,
   output reg  [`OTSC_N_AXIS-1:0]             pos_inhibit_out,
   output reg  [`OTSC_N_AXIS-1:0]             neg_inhibit_out,
   output reg  [`OTSC_N_AXIS-1:0]             drive_enable_out,
   output reg  [`OTSC_N_AXIS-1:0]             plug_brake_out,
   output reg  [`OTSC_N_AXIS-1:0]             zero_clamp_out,
   output reg  [`OTSC_N_AXIS*`OTSC_TQ_W-1:0]  torque_limit_out,
   output reg  [`OTSC_N_OUT-1:0]              brake_release_out,
   output reg                                 cfg_loaded_out
);

   // one-hot stop states
   localparam [`OTSC_ST_W-1:0] ST_RUN   = 4'h1;
   localparam [`OTSC_ST_W-1:0] ST_BRAKE = 4'h2;
   localparam [`OTSC_ST_W-1:0] ST_COAST = 4'h4;
   localparam [`OTSC_ST_W-1:0] ST_CLAMP = 4'h8;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg rst_s1;
   reg rst_n;

   // reset asserts at once and releases two edges later
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // ----------------------------------------------------------------
   // terminal conditioning
   // ----------------------------------------------------------------
   wire [`OTSC_N_TERM-1:0] term;
   genvar t;

   generate
      for (t = 0; t < `OTSC_N_TERM; t = t + 1)
      begin : g_term
         otsc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_db
         (
            .clk_in    (clk_in),
            .rstn_in   (rst_n),
            .ce_in     (ce_in),
            .pin_in    (term_in[t]),
            .level_out (term[t])
         );
      end
   endgenerate

   // pick a terminal by code; out-of-range codes read as no limit
   function pick;
      input [`OTSC_SEL_W-1:0]   sel;
      input [`OTSC_N_TERM-1:0]  pins;
      reg   [`OTSC_SEL_W-1:0]   idx;
      begin
         idx  = sel - `OTSC_SEL_FIRST;
         pick = 1'b0;
         if (sel >= `OTSC_SEL_FIRST && sel <= `OTSC_SEL_LAST)
            pick = pins[idx[2:0]];
      end
   endfunction

   // ----------------------------------------------------------------
   // power-up configuration latch
   // ----------------------------------------------------------------
   reg [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] pos_sel;
   reg [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] neg_sel;
   reg [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] stop_mid;
   reg [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] stop_top;
   reg [`OTSC_N_AXIS*`OTSC_SEL_W-1:0] brake_sel;

   // capture once after release; later edits wait for a reset
   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pos_sel        <= {`OTSC_POS_SEL_B_DEF, `OTSC_POS_SEL_A_DEF};
         neg_sel        <= {`OTSC_NEG_SEL_B_DEF, `OTSC_NEG_SEL_A_DEF};
         stop_mid       <= {`OTSC_MID_PLUG, `OTSC_MID_PLUG};
         stop_top       <= {`OTSC_TOP_PLUG, `OTSC_TOP_PLUG};
         brake_sel      <= {`OTSC_BK_NONE, `OTSC_BK_NONE};
         cfg_loaded_out <= 1'b0;
      end
      else if (ce_in && !cfg_loaded_out)
      begin
         pos_sel        <= cfg_pos_sel_in;
         neg_sel        <= cfg_neg_sel_in;
         stop_mid       <= cfg_stop_mid_in;
         stop_top       <= cfg_stop_top_in;
         brake_sel      <= cfg_brake_sel_in;
         cfg_loaded_out <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // per-axis stop sequencer
   // ----------------------------------------------------------------
   wire [`OTSC_N_AXIS-1:0] hold_brake;
   genvar a;

   generate
      for (a = 0; a < `OTSC_N_AXIS; a = a + 1)
      begin : g_axis
         reg  [`OTSC_ST_W-1:0] state;
         reg  [`OTSC_ST_W-1:0] next_state;
         reg                   blocked_pos;
         reg                   servo_q;
         reg  [`OTSC_TQ_W-1:0] stop_tq;
         wire [`OTSC_SEL_W-1:0] mid = stop_mid[a*`OTSC_SEL_W +: `OTSC_SEL_W];
         wire [`OTSC_SEL_W-1:0] top = stop_top[a*`OTSC_SEL_W +: `OTSC_SEL_W];
         wire [`OTSC_TQ_W-1:0]  set_tq = stop_torque_in[a*`OTSC_TQ_W +: `OTSC_TQ_W];
         wire [`OTSC_TQ_W-1:0]  max_tq = max_torque_in[a*`OTSC_TQ_W +: `OTSC_TQ_W];
         wire pos_lim = pick(pos_sel[a*`OTSC_SEL_W +: `OTSC_SEL_W], term);
         wire neg_lim = pick(neg_sel[a*`OTSC_SEL_W +: `OTSC_SEL_W], term);
         // trigger ignores the control mode entirely
         wire hit     = moving_in[a] &&
                        ((dir_pos_in[a] && pos_lim) || (!dir_pos_in[a] && neg_lim));
         wire blk_lim = blocked_pos ? pos_lim : neg_lim;
         // a command away from the blocked side is let through
         wire reverse = cmd_move_in[a] && (cmd_dir_pos_in[a] != blocked_pos);
         // coasting stop chosen by the top digit, or by the mid digit when top is plug
         wire coast_m = (top == `OTSC_TOP_COAST) ||
                        (top == `OTSC_TOP_PLUG && mid == `OTSC_MID_COAST);

         // stop torque held within 0..300 percent
         // and never above the motor's own maximum
         always @*
         begin
            stop_tq = (set_tq > `OTSC_TQ_LIMIT) ? `OTSC_TQ_LIMIT : set_tq;
            if (stop_tq > max_tq)
               stop_tq = max_tq;
         end

         // next state of the stop sequence
         always @*
         begin
            next_state = state;
            case (state)
               ST_RUN:
               begin
                  if (hit && cfg_loaded_out)
                     next_state = coast_m ? ST_COAST : ST_BRAKE;
               end
               ST_BRAKE:
               begin
                  // plug stop ends in coast unless clamp asked
                  // top digit one ends in zero clamp
                  if (stopped_in[a])
                     next_state = (top == `OTSC_TOP_CLAMP) ? ST_CLAMP : ST_COAST;
               end
               ST_COAST:
               begin
                  // fresh servo-enable edge takes control back
                  if ((servo_on_in[a] && !servo_q) || !blk_lim || reverse)
                     next_state = ST_RUN;
               end
               ST_CLAMP:
               begin
                  if (!blk_lim || reverse)
                     next_state = ST_RUN;
               end
               default:
                  next_state = ST_RUN;
            endcase
         end

         // state, blocked side and registered axis outputs
         always @(posedge clk_in or negedge rst_n)
         begin
            if (!rst_n)
            begin
               state                   <= ST_RUN;
               blocked_pos             <= 1'b0;
               servo_q                 <= 1'b0;
               pos_inhibit_out[a]      <= 1'b0;
               neg_inhibit_out[a]      <= 1'b0;
               drive_enable_out[a]     <= 1'b0;
               plug_brake_out[a]       <= 1'b0;
               zero_clamp_out[a]       <= 1'b0;
               torque_limit_out[a*`OTSC_TQ_W +: `OTSC_TQ_W] <= {`OTSC_TQ_W{1'b0}};
            end
            else if (ce_in)
            begin
               state   <= next_state;
               servo_q <= servo_on_in[a];
               if (state == ST_RUN && hit)
                  blocked_pos <= dir_pos_in[a];
               pos_inhibit_out[a] <= pos_lim;
               neg_inhibit_out[a] <= neg_lim;
               // coasting removes drive just like servo-off
               drive_enable_out[a] <= (next_state == ST_RUN && servo_on_in[a]) ||
                                      next_state == ST_BRAKE ||
                                      next_state == ST_CLAMP;
               plug_brake_out[a] <= (next_state == ST_BRAKE);
               // clamp means position loop at zero reference
               zero_clamp_out[a] <= (next_state == ST_CLAMP);
               // limited torque only while plug braking
               torque_limit_out[a*`OTSC_TQ_W +: `OTSC_TQ_W] <=
                  (next_state == ST_BRAKE) ? stop_tq : max_tq;
            end
         end

         // brake holds whenever the motor is not driven
         assign hold_brake[a] = ~drive_enable_out[a];
      end
   endgenerate

   // ----------------------------------------------------------------
   // brake output terminal routing
   // ----------------------------------------------------------------
   reg [`OTSC_N_OUT-1:0] next_brake;
   integer o;
   integer x;

   // route brake signal; shared terminals are or-ed
   always @*
   begin
      next_brake = {`OTSC_N_OUT{1'b0}};
      for (o = 0; o < `OTSC_N_OUT; o = o + 1)
         for (x = 0; x < `OTSC_N_AXIS; x = x + 1)
            if (brake_sel[x*`OTSC_SEL_W +: `OTSC_SEL_W] ==
                `OTSC_BK_FIRST + o[`OTSC_SEL_W-1:0])
               next_brake[o] = next_brake[o] | hold_brake[x];
   end

   // registered terminal drive, high holds the brake
   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         brake_release_out <= {`OTSC_N_OUT{1'b0}};
      else if (ce_in)
         brake_release_out <= next_brake;
   end

endmodule
`default_nettype wire

// ---- testbench/otsc_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "otsc_defs.vh"

module otsc_top_sva
#(
   parameter [`OTSC_DB_CW-1:0] DEBOUNCE_CYCLES = `OTSC_DB_CYCLES
)
(
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic [1:0]  servo_on_in,
   input wire logic [1:0]  moving_in,
   input wire logic [1:0]  dir_pos_in,
   input wire logic [1:0]  stopped_in,
   input wire logic [17:0] stop_torque_in,
   input wire logic [17:0] max_torque_in,
   input wire logic [1:0]  pos_inhibit_out,
   input wire logic [1:0]  neg_inhibit_out,
   input wire logic [1:0]  drive_enable_out,
   input wire logic [1:0]  plug_brake_out,
   input wire logic [1:0]  zero_clamp_out,
   input wire logic [17:0] torque_limit_out,
   input wire logic        cfg_loaded_out
);
   // ----------------------------------------
   // axis A checks, with the brake end and clamp checks on axis B
   // ----------------------------------------
   logic [8:0] cap;
   logic [8:0] exp_tq;

   // stop torque capped at 300, then at the motor maximum
   always_comb
   begin
      cap = (stop_torque_in[8:0] > 9'h12c) ? 9'h12c : stop_torque_in[8:0];
      exp_tq = (cap > max_torque_in[8:0]) ? max_torque_in[8:0] : cap;
   end

   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   // normal running, no stop in progress
   sequence s_run;
      cfg_loaded_out && drive_enable_out[0] && !plug_brake_out[0] && !zero_clamp_out[0];
   endsequence

   // inhibit shows the limit on the same edge that the stop logic acts on it
   sequence s_hit_pos;
      moving_in[0] && dir_pos_in[0] ##1 pos_inhibit_out[0];
   endsequence

   chk_limit_stop: assert property (
      s_run ##0 s_hit_pos |-> plug_brake_out[0] || !drive_enable_out[0])
      else $error("limit hit while running did not stop the axis");
   chk_opposite_free: assert property (
      s_run ##0 (moving_in[0] && !dir_pos_in[0] && pos_inhibit_out[0]
      && !neg_inhibit_out[0] && servo_on_in[0]) |=> drive_enable_out[0] && !plug_brake_out[0])
      else $error("travel away from the limit was stopped");
   chk_brake_end: assert property (
      plug_brake_out[1] && stopped_in[1]
      |=> !plug_brake_out[1] && (zero_clamp_out[1] == drive_enable_out[1]))
      else $error("braking did not end in clamp or coast");
   chk_clamp_powered: assert property (
      zero_clamp_out[1] |-> drive_enable_out[1] && !plug_brake_out[1]
      && ($past(zero_clamp_out[1]) || $past(plug_brake_out[1])))
      else $error("zero clamp without position loop drive");
   chk_cfg_held: assert property (
      cfg_loaded_out |=> cfg_loaded_out)
      else $error("configuration dropped without reset");
   chk_no_early: assert property (
      !cfg_loaded_out |-> plug_brake_out == 2'h0 && zero_clamp_out == 2'h0)
      else $error("stop action before configuration");
   chk_plug_torque: assert property (
      plug_brake_out[0] && $past(plug_brake_out[0]) && $stable(exp_tq)
      |-> torque_limit_out[8:0] == $past(exp_tq))
      else $error("braking torque limit wrong");
   chk_run_torque: assert property (
      cfg_loaded_out && $past(cfg_loaded_out) && !plug_brake_out[0]
      && !$past(plug_brake_out[0]) && $stable(max_torque_in)
      |-> torque_limit_out[8:0] == max_torque_in[8:0])
      else $error("torque limit not at maximum outside braking");
endmodule

bind otsc_top otsc_top_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_sva (
   .clk_in(clk_in), .rstn_in(rstn_in), .servo_on_in(servo_on_in),
   .moving_in(moving_in), .dir_pos_in(dir_pos_in), .stopped_in(stopped_in),
   .stop_torque_in(stop_torque_in), .max_torque_in(max_torque_in),
   .pos_inhibit_out(pos_inhibit_out), .neg_inhibit_out(neg_inhibit_out),
   .drive_enable_out(drive_enable_out), .plug_brake_out(plug_brake_out),
   .zero_clamp_out(zero_clamp_out), .torque_limit_out(torque_limit_out),
   .cfg_loaded_out(cfg_loaded_out));
`default_nettype wire

// ---- testbench/otsc_limit_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module otsc_limit_model
(
   input  wire logic       clk_in,
   input  wire logic [7:0] engage_in,
   input  wire logic       bounce_in,
   output var  logic [7:0] term_out
);
   // ----------------------------------------
   // limit switch contacts
   // ----------------------------------------
   logic flip = 1'h0;

   initial term_out = 8'h00;

   // chatter flips every cycle, always shorter than the filter
   always @(posedge clk_in)
   begin
      flip <= ~flip;
      term_out <= engage_in ^ {8{bounce_in & flip}};
   end
endmodule
`default_nettype wire

// ---- testbench/overtravel_stop_control_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module overtravel_stop_control_test;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   logic        clk_in = 1'h0;
   logic        rstn_in = 1'h0;
   logic [7:0]  engage = 8'h00;
   logic        bounce = 1'h0;
   logic [7:0]  cfg_pos = 8'h92;
   logic [7:0]  cfg_neg = 8'h84;
   logic [7:0]  mid = 8'h00;
   logic [7:0]  top = 8'h10;
   logic [7:0]  bk = 8'h21;
   logic [17:0] stq = {9'h064, 9'h190};
   logic [17:0] mtq = {9'h0c8, 9'h15e};
   logic [1:0]  son = 2'h3;
   logic [1:0]  mov = 2'h0;
   logic [1:0]  dpos = 2'h1;
   logic [1:0]  stp = 2'h0;
   logic [1:0]  cmv = 2'h0;
   logic [1:0]  cdp = 2'h0;
   wire  [7:0]  term;
   wire  [1:0]  pos_inh, neg_inh, drv, plug, clamp;
   wire  [17:0] tq;
   wire  [5:0]  brk;
   wire         loaded;
   int          n_fail = 0;
   int          checks_done = 0;
   int          k;

   // 200 MHz clock
   always #2.5 clk_in = ~clk_in;

   otsc_limit_model u_sw (.clk_in(clk_in), .engage_in(engage), .bounce_in(bounce),
      .term_out(term));

   otsc_top #(.DEBOUNCE_CYCLES(16'h0004)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
      .ce_in(1'h1), .term_in(term), .cfg_pos_sel_in(cfg_pos), .cfg_neg_sel_in(cfg_neg),
      .cfg_stop_mid_in(mid), .cfg_stop_top_in(top), .cfg_brake_sel_in(bk),
      .stop_torque_in(stq), .max_torque_in(mtq), .servo_on_in(son), .moving_in(mov),
      .dir_pos_in(dpos), .stopped_in(stp), .cmd_move_in(cmv), .cmd_dir_pos_in(cdp),
      .pos_inhibit_out(pos_inh), .neg_inhibit_out(neg_inh), .drive_enable_out(drv),
      .plug_brake_out(plug), .zero_clamp_out(clamp), .torque_limit_out(tq),
      .brake_release_out(brk), .cfg_loaded_out(loaded));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task cyc(input int n);
   begin
      repeat (n) @(posedge clk_in);
   end
   endtask

   task chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
   begin
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   end
   endtask

   // reset held 4 cycles, then a bounded wait for the capture
   task do_reset;
   begin
      rstn_in <= 1'h0;
      cyc(4);
      rstn_in <= 1'h1;
      for (k = 0; k < 10 && loaded !== 1'h1; k++)
      begin
         @(posedge clk_in);
         #1;
      end
      chk("loaded", loaded, 1'h1);
      cyc(1);
   end
   endtask

   task summarize;
   begin
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      do_reset;
      // later settings must wait for the next reset
      cfg_pos <= 8'h33;
      cfg_neg <= 8'h99;
      mid <= 8'h11;
      top <= 8'h22;
      bounce <= 1'h1;
      engage <= 8'h04;
      mov <= 2'h3;
      cyc(20);
      #1;
      chk("pos_inhibit", pos_inh, 2'h0);
      chk("neg_inhibit", neg_inh, 2'h0);
      chk("drive", drv, 2'h3);
      cyc(1);
      bounce <= 1'h0;
      engage <= 8'hc2;
      cyc(14);
      #1;
      chk("pos_inhibit", pos_inh, 2'h1);
      chk("neg_inhibit", neg_inh, 2'h2);
      chk("plug", plug, 2'h3);
      chk("torque", tq, {9'h064, 9'h12c});
      cyc(1);
      stp <= 2'h3;
      cyc(1);
      #1;
      chk("drive", drv, 2'h2);
      chk("clamp", clamp, 2'h2);
      chk("plug", plug, 2'h0);
      cyc(1);
      #1;
      chk("brake", brk, 6'h01);
      cyc(1);
      stp <= 2'h0;
      dpos <= 2'h0;
      cmv <= 2'h1;
      cyc(3);
      #1;
      chk("drive", drv, 2'h3);
      chk("brake", brk, 6'h00);
      cyc(1);
      cfg_pos <= 8'h92;
      cfg_neg <= 8'h84;
      mid <= 8'h10;
      top <= 8'h02;
      mov <= 2'h3;
      dpos <= 2'h1;
      cmv <= 2'h0;
      do_reset;
      cyc(14);
      #1;
      chk("drive", drv, 2'h0);
      chk("plug", plug, 2'h0);
      cyc(1);
      mov <= 2'h0;
      son <= 2'h2;
      cyc(2);
      son <= 2'h3;
      cyc(2);
      #1;
      chk("drive", drv[0], 1'h1);
      summarize;
   end

   // hang guard at 2000 cycles, far beyond the roughly 80 cycles needed
   initial
   begin
      #(5 * 2000);
      n_fail++;
      summarize;
   end
endmodule
`default_nettype wire
